//--- hw/csu_defs.vh
// Constants for the conditional skip unit
// Overview of operation
// RULE1 - Immediate compare: skip when equal
// RULE2 - Memory compare: skip when equal
// RULE3 - Memory compare: skip when unequal
// RULE4 - Immediate compare: skip when unequal
// RULE5 - Compares set flags as subtraction
// RULE6 - Port bit low: skip, flags kept
// RULE7 - Port bit high: skip, flags kept
// RULE8 - Memory bit low: skip, flags kept
// RULE9 - Memory bit high: skip, flags kept
// RULE10 - Increment register, skip on zero, flags
// RULE11 - Decrement register, skip on zero, flags
// RULE12 - Increment memory, write back, skip zero
// RULE13 - Decrement memory, write back, skip zero
// RULE14 - Skip squashes next instruction, advances counter
`ifndef CSU_DEFS_VH
`define CSU_DEFS_VH

// ==========================================================
// Operation codes
`define CSU_OP_W        4
`define CSU_OP_NONE     4'h0
`define CSU_OP_CEQ_IMM  4'h1
`define CSU_OP_CEQ_MEM  4'h2
`define CSU_OP_CNE_MEM  4'h3
`define CSU_OP_CNE_IMM  4'h4
`define CSU_OP_T0_IO    4'h5
`define CSU_OP_T1_IO    4'h6
`define CSU_OP_T0_MEM   4'h7
`define CSU_OP_T1_MEM   4'h8
`define CSU_OP_INC_ACC  4'h9
`define CSU_OP_DEC_ACC  4'hA
`define CSU_OP_INC_MEM  4'hB
`define CSU_OP_DEC_MEM  4'hC

// ==========================================================
// Flag field positions
`define CSU_FLAG_Z      0
`define CSU_FLAG_C      1
`define CSU_FLAG_HB     2
`define CSU_FLAG_SR     3

// ==========================================================
// Reset values
`define CSU_ACC_RST     8'h00
`define CSU_FLAGS_RST   4'h0
`define CSU_PC_RST      12'h000

`endif

//--- hw/csu_alu.v
// Eight bit subtract and add with flag generation
`include "csu_defs.vh"
module csu_alu (
    // Operands
    input  wire [7:0] i_a,
    input  wire [7:0] i_b,
    input  wire       i_sub,
    // Result
    output wire [7:0] o_res,
    output wire [3:0] o_flags
);
    wire [8:0] full;
    wire [4:0] half;
    wire       ovf;

    assign full  = i_sub ? ({1'b0, i_a} - {1'b0, i_b}) : ({1'b0, i_a} + {1'b0, i_b});
    assign half  = i_sub ? ({1'b0, i_a[3:0]} - {1'b0, i_b[3:0]}) : ({1'b0, i_a[3:0]} + {1'b0, i_b[3:0]});
    assign ovf   = i_sub ? ((i_a[7] ^ i_b[7]) & (i_a[7] ^ full[7]))
                         : (~(i_a[7] ^ i_b[7]) & (i_a[7] ^ full[7]));
    assign o_res = full[7:0];
    assign o_flags = {ovf, half[4], full[8], (full[7:0] == 8'h00)};
endmodule

//--- hw/csu_core.v
// Conditional skip instruction execution unit
`include "csu_defs.vh"
module csu_core #(
    parameter PC_W = 12
) (
    // Clock and reset
    input  wire                 i_core_clk,
    input  wire                 i_sys_rst,
    // Decoded instruction
    input  wire                 i_valid,
    input  wire [`CSU_OP_W-1:0] i_op,
    input  wire [7:0]           i_imm,
    input  wire [2:0]           i_bit_sel,
    // Operand sources
    input  wire [7:0]           i_mem_rdata,
    input  wire [7:0]           i_first_io_port,
    // Program counter
    output reg  [PC_W-1:0]      o_pc,
    // Working register and flags
    output reg  [7:0]           o_working_register,
    output reg  [3:0]           o_flags,
    // Memory write back
    output reg                  o_mem_we,
    output reg  [7:0]           o_mem_wdata,
    // Skip status
    output reg                  o_skip,
    output reg                  o_squashed
);
    // ==========================================================
    // Pin synchroniser for the port
    reg  [7:0] io_s1_reg;
    reg  [7:0] io_s2_reg;
    reg  [7:0] io_s3_reg;
    reg  [7:0] io_val_reg;

    always @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            io_s1_reg  <= 8'h00;
            io_s2_reg  <= 8'h00;
            io_s3_reg  <= 8'h00;
            io_val_reg <= 8'h00;
        end else begin
            io_s1_reg  <= i_first_io_port;
            io_s2_reg  <= io_s1_reg;
            io_s3_reg  <= io_s2_reg;
            io_val_reg <= (io_s2_reg & ~(io_s2_reg ^ io_s3_reg)) | (io_val_reg & (io_s2_reg ^ io_s3_reg));
        end
    end

    // ==========================================================
    // Arithmetic
    reg  [7:0] alu_a;
    reg  [7:0] alu_b;
    reg        alu_sub;
    wire [7:0] alu_res;
    wire [3:0] alu_flags;

    csu_alu u_alu (
        .i_a     (alu_a),
        .i_b     (alu_b),
        .i_sub   (alu_sub),
        .o_res   (alu_res),
        .o_flags (alu_flags)
    );

    // ==========================================================
    // Decode and skip decision
    reg        skip_next;
    reg        upd_flags;
    reg        upd_acc;
    reg        upd_mem;
    reg        live;

    always @* begin
        alu_a     = o_working_register;
        alu_b     = 8'h01;
        alu_sub   = 1'b1;
        skip_next = 1'b0;
        upd_flags = 1'b0;
        upd_acc   = 1'b0;
        upd_mem   = 1'b0;
        live      = i_valid & ~o_skip; // RULE14
        case (i_op)
            `CSU_OP_CEQ_IMM: begin
                alu_b     = i_imm;
                upd_flags = 1'b1; // RULE5
                skip_next = alu_flags[`CSU_FLAG_Z]; // RULE1
            end
            `CSU_OP_CEQ_MEM: begin
                alu_b     = i_mem_rdata;
                upd_flags = 1'b1; // RULE5
                skip_next = alu_flags[`CSU_FLAG_Z]; // RULE2
            end
            `CSU_OP_CNE_MEM: begin
                alu_b     = i_mem_rdata;
                upd_flags = 1'b1; // RULE5
                skip_next = ~alu_flags[`CSU_FLAG_Z]; // RULE3
            end
            `CSU_OP_CNE_IMM: begin
                alu_b     = i_imm;
                upd_flags = 1'b1; // RULE5
                skip_next = ~alu_flags[`CSU_FLAG_Z]; // RULE4
            end
            `CSU_OP_T0_IO: begin
                skip_next = ~io_val_reg[i_bit_sel]; // RULE6
            end
            `CSU_OP_T1_IO: begin
                skip_next = io_val_reg[i_bit_sel]; // RULE7
            end
            `CSU_OP_T0_MEM: begin
                skip_next = ~i_mem_rdata[i_bit_sel]; // RULE8
            end
            `CSU_OP_T1_MEM: begin
                skip_next = i_mem_rdata[i_bit_sel]; // RULE9
            end
            `CSU_OP_INC_ACC: begin
                alu_sub   = 1'b0;
                upd_flags = 1'b1;
                upd_acc   = 1'b1;
                skip_next = alu_flags[`CSU_FLAG_Z]; // RULE10
            end
            `CSU_OP_DEC_ACC: begin
                upd_flags = 1'b1;
                upd_acc   = 1'b1;
                skip_next = alu_flags[`CSU_FLAG_Z]; // RULE11
            end
            `CSU_OP_INC_MEM: begin
                alu_a     = i_mem_rdata;
                alu_sub   = 1'b0;
                upd_flags = 1'b1;
                upd_mem   = 1'b1;
                skip_next = alu_flags[`CSU_FLAG_Z]; // RULE12
            end
            `CSU_OP_DEC_MEM: begin
                alu_a     = i_mem_rdata;
                upd_flags = 1'b1;
                upd_mem   = 1'b1;
                skip_next = alu_flags[`CSU_FLAG_Z]; // RULE13
            end
            default: begin
                skip_next = 1'b0;
            end
        endcase
    end

    // ==========================================================
    // Architectural state
    always @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_pc               <= `CSU_PC_RST;
            o_working_register <= `CSU_ACC_RST;
            o_flags            <= `CSU_FLAGS_RST;
            o_mem_we           <= 1'b0;
            o_mem_wdata        <= 8'h00;
            o_skip             <= 1'b0;
            o_squashed         <= 1'b0;
        end else begin
            o_mem_we   <= 1'b0;
            o_squashed <= 1'b0;
            if (i_valid) begin
                o_pc <= o_pc + {{(PC_W-1){1'b0}}, 1'b1}; // RULE14
                if (o_skip) begin
                    o_skip     <= 1'b0; // RULE14
                    o_squashed <= 1'b1; // RULE14
                end else begin
                    o_skip <= skip_next;
                end
            end
            if (live && upd_flags) begin
                o_flags <= alu_flags;
            end
            if (live && upd_acc) begin
                o_working_register <= alu_res;
            end
            if (live && upd_mem) begin
                o_mem_we    <= 1'b1; // RULE12
                o_mem_wdata <= alu_res; // RULE13
            end
        end
    end
endmodule

//--- tb/csu_core_monitor.sv
// Checker for the conditional skip unit
`include "csu_defs.vh"
module csu_core_monitor #(parameter PC_W = 12) (
    input wire            i_core_clk, i_sys_rst, i_valid,
    input wire [3:0]      i_op,
    input wire [7:0]      i_imm, i_mem_rdata, i_first_io_port,
    input wire [2:0]      i_bit_sel,
    input wire [PC_W-1:0] o_pc,
    input wire [7:0]      o_working_register, o_mem_wdata,
    input wire [3:0]      o_flags,
    input wire            o_mem_we, o_skip, o_squashed
);
    timeunit 1ns;
    timeprecision 1ps;
    wire go = i_valid && !o_skip;
    wire [7:0] wr = o_working_register;
    wire [3:0] op = i_op;
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_sys_rst);
    // ==========
    // Assertions
    pc_step_a: assert property (i_valid |=> o_pc == $past(o_pc + 1'b1)) else $error("pc");
    squash_hold_a: assert property (i_valid && o_skip |=> !o_skip && o_squashed &&
        !o_mem_we && $stable(o_flags) && $stable(wr)) else $error("squash");
    ceq_imm_a: assert property (go && op == 4'h1 |=> o_skip == $past(wr == i_imm)) else $error("ceq");
    cne_imm_a: assert property (go && op == 4'h4 |=> o_skip == $past(wr != i_imm)) else $error("cne");
    cmp_mem_a: assert property (go && (op == 4'h2 || op == 4'h3) |=>
        o_skip == $past((wr == i_mem_rdata) == (op == 4'h2))) else $error("cmp mem");
    imm_flags_a: assert property (go && (op == 4'h1 || op == 4'h4) |=>
        o_flags[1:0] == $past({wr < i_imm, wr == i_imm})) else $error("cmp flags");
    bit_flags_a: assert property (go && op >= 4'h5 && op <= 4'h8 |=>
        $stable(o_flags)) else $error("bit flags");
    acc_step_a: assert property (go && (op == 4'h9 || op == 4'hA) |=>
        wr == $past(op == 4'h9 ? wr + 8'h01 : wr - 8'h01) && o_skip == (wr == 8'h00)) else $error("acc");
    mem_step_a: assert property (go && (op == 4'hB || op == 4'hC) |=> o_mem_we &&
        o_mem_wdata == $past(op == 4'hB ? i_mem_rdata + 8'h01 : i_mem_rdata - 8'h01)
        && o_skip == (o_mem_wdata == 8'h00)) else $error("mem");
    mem_bit_skip_a: assert property (go && (op == 4'h7 || op == 4'h8) |=>
        o_skip == $past(i_mem_rdata[i_bit_sel] == (op == 4'h8))) else $error("mem bit");
    cover property (go && op == 4'hB);
    cover property (i_valid && o_skip);
    cover property (go && op == 4'h6);
endmodule
bind csu_core csu_core_monitor #(.PC_W(PC_W)) u_csu_core_monitor (.i_core_clk, .i_sys_rst, .i_valid,
    .i_op, .i_imm, .i_bit_sel, .i_mem_rdata, .i_first_io_port, .o_pc, .o_working_register, .o_flags,
    .o_mem_we, .o_mem_wdata, .o_skip, .o_squashed);

//--- tb/csu_core_tb.sv
// Self-checking bench for the conditional skip unit
module csu_core_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        i_core_clk = 1'b0, i_sys_rst = 1'b1, i_valid = 1'b0, ps = 1'b0;
    logic [3:0]  i_op = 4'h0;
    logic [7:0]  i_imm = 8'h00, i_mem_rdata = 8'h00, i_first_io_port = 8'h20;
    logic [2:0]  i_bit_sel = 3'h0;
    wire  [11:0] o_pc;
    wire  [7:0]  o_working_register, o_mem_wdata;
    wire  [3:0]  o_flags;
    wire         o_mem_we, o_skip, o_squashed;
    integer      n_errors = 0, comparisons = 0, n_pc = 0;
    csu_core u_csu_core (.i_core_clk, .i_sys_rst, .i_valid, .i_op, .i_imm, .i_bit_sel, .i_mem_rdata,
        .i_first_io_port, .o_pc, .o_working_register, .o_flags, .o_mem_we, .o_mem_wdata, .o_skip,
        .o_squashed);
    initial forever #2.5 i_core_clk = ~i_core_clk;
    // ==========
    // Tasks
    task chk(input string nm, input logic [11:0] e, g);
        comparisons++;
        if (g !== e) begin
            n_errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task ex(input logic [3:0] op, input logic [7:0] im, md, input logic sk, input logic [3:0] fl,
            input logic [7:0] ac, input logic we = 1'b0, input logic [7:0] wd = 8'h00);
        i_valid <= 1'b1;
        i_op <= op;
        i_imm <= im;
        i_bit_sel <= im[2:0];
        i_mem_rdata <= md;
        @(posedge i_core_clk);
        i_valid <= 1'b0;
        n_pc++;
        #1;
        chk("pc", n_pc, o_pc);
        chk("squashed", ps, o_squashed);
        chk("skip", sk, o_skip);
        chk("flags", fl, o_flags);
        chk("acc", ac, o_working_register);
        chk("mem_we", we, o_mem_we);
        if (we) chk("wdata", wd, o_mem_wdata);
        ps = sk;
        @(posedge i_core_clk);
    endtask
    task conclude;
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // ==========
    // Sequence
    initial begin
        repeat (4) @(posedge i_core_clk);
        i_sys_rst <= 1'b0;
        @(posedge i_core_clk);
        ex(4'h1, 8'h00, 8'h00, 1, 4'h1, 8'h00);
        ex(4'hB, 8'h00, 8'h05, 0, 4'h1, 8'h00);
        ex(4'hA, 8'h00, 8'h00, 0, 4'h6, 8'hFF);
        ex(4'h4, 8'hFF, 8'h00, 0, 4'h1, 8'hFF);
        ex(4'h9, 8'h00, 8'h00, 1, 4'h7, 8'h00);
        ex(4'hA, 8'h00, 8'h00, 0, 4'h7, 8'h00);
        ex(4'h4, 8'h80, 8'h00, 1, 4'hA, 8'h00);
        ex(4'h2, 8'h00, 8'h00, 0, 4'hA, 8'h00);
        ex(4'h2, 8'h00, 8'h01, 0, 4'h6, 8'h00);
        ex(4'h3, 8'h00, 8'h00, 0, 4'h1, 8'h00);
        ex(4'h3, 8'h00, 8'h7F, 1, 4'h6, 8'h00);
        ex(4'h2, 8'h00, 8'h00, 0, 4'h6, 8'h00);
        ex(4'hB, 8'h00, 8'hFF, 1, 4'h7, 8'h00, 1, 8'h00);
        ex(4'hC, 8'h00, 8'h03, 0, 4'h7, 8'h00);
        ex(4'hC, 8'h00, 8'h80, 0, 4'hC, 8'h00, 1, 8'h7F);
        ex(4'hC, 8'h00, 8'h01, 1, 4'h1, 8'h00, 1, 8'h00);
        ex(4'h8, 8'h07, 8'h80, 0, 4'h1, 8'h00);
        ex(4'h8, 8'h07, 8'h80, 1, 4'h1, 8'h00);
        ex(4'h7, 8'h00, 8'hFE, 0, 4'h1, 8'h00);
        ex(4'h7, 8'h00, 8'hFE, 1, 4'h1, 8'h00);
        ex(4'h5, 8'h05, 8'h00, 0, 4'h1, 8'h00);
        ex(4'h5, 8'h05, 8'h00, 0, 4'h1, 8'h00);
        ex(4'h6, 8'h05, 8'h00, 1, 4'h1, 8'h00);
        ex(4'h6, 8'h04, 8'h00, 0, 4'h1, 8'h00);
        ex(4'h5, 8'h04, 8'h00, 1, 4'h1, 8'h00);
        ex(4'h0, 8'h00, 8'h00, 0, 4'h1, 8'h00);
        i_first_io_port <= 8'h00;
        repeat (6) @(posedge i_core_clk);
        ex(4'h5, 8'h05, 8'h00, 1, 4'h1, 8'h00);
        ex(4'h0, 8'h00, 8'h00, 0, 4'h1, 8'h00);
        ex(4'h2, 8'h00, 8'h00, 1, 4'h1, 8'h00);
        ex(4'h0, 8'h00, 8'h00, 0, 4'h1, 8'h00);
        conclude;
    end
endmodule
